// ### hdl/ddc_top.sv
`timescale 1ns/1ns
`include "ddc_map.svh"

module ddc_top
    import ddc_pkg::*;
#(
    parameter int REACT_CYC = `DDC_REACT_MS * `DDC_CLK_KHZ,
    parameter int SILENT_CYC = (`DDC_CLK_KHZ / `DDC_LINK_KBPS) * `DDC_SILENT_BITS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ddc_chan_s ch_a,
    input wire logic ch_a_valid,
    input wire ddc_chan_s ch_b,
    input wire logic ch_b_valid,
    input wire logic link_clk,
    input wire logic link_data,
    output ddc_merge_s merged,
    output logic merged_valid,
    output logic div_fail,
    output logic raw_bit,
    output logic raw_valid,
    output logic hs_confirm,
    output logic reaction
);
    localparam int TW = $clog2(REACT_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [31:0] ctrl_q;
    logic [31:0] expid_q;
    logic [`DDC_ST_W-1:0] stat_q;
    logic [`DDC_ST_W-1:0] stat_set;
    logic wr_q;
    logic [7:0] waddr_q;
    logic [31:0] rdata_mux;
    logic [15:0] raw_shift_q;
    logic [7:0] raw_cnt_q;

    wire addr_phase = hsel & htrans[1] & hready;
    wire [7:0] aoff = haddr[7:0];
    wire wr_ctrl = wr_q & (waddr_q == `DDC_CTRL_OFS);
    wire wr_expid = wr_q & (waddr_q == `DDC_EXPID_OFS);
    wire wr_stat = wr_q & (waddr_q == `DDC_STAT_OFS);
    wire [`DDC_ST_W-1:0] stat_clr = wr_stat ? hwdata[`DDC_ST_W-1:0] : '0;

    wire link_used = ctrl_q[`DDC_CTRL_LINK_USED];
    wire simple_mode = ctrl_q[`DDC_CTRL_SIMPLE];
    wire [1:0] op_state = ctrl_q[`DDC_CTRL_OPST_LO +: 2];
    wire hs_request = ctrl_q[`DDC_CTRL_HSREQ];
    wire [`DDC_LID_W-1:0] exp_lid_a = expid_q[`DDC_EXPID_A_LO +: `DDC_LID_W];
    wire [`DDC_LID_W-1:0] exp_lid_b = expid_q[`DDC_EXPID_B_LO +: `DDC_LID_W];
    wire op_ok = (op_state == `DDC_OP_HS) | (op_state == `DDC_OP_DA);

    always_comb begin
        case (aoff)
            `DDC_CTRL_OFS: rdata_mux = ctrl_q;
            `DDC_EXPID_OFS: rdata_mux = expid_q;
            `DDC_STAT_OFS: rdata_mux = {{(32 - `DDC_ST_W){1'b0}}, stat_q};
            `DDC_MERGE_OFS: rdata_mux = {{(32 - $bits(ddc_merge_s) - 1){1'b0}}, merged_valid, merged};
            `DDC_RAW_OFS: rdata_mux = {raw_cnt_q, 8'h00, raw_shift_q};
            default: rdata_mux = 32'h0000_0000;
        endcase
    end

    // Zero wait states: read data is prepared during the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_q <= addr_phase & hwrite;
            waddr_q <= aoff;
            if (addr_phase & ~hwrite) begin
                hrdata <= rdata_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `DDC_CTRL_RST;
            expid_q <= `DDC_EXPID_RST;
            stat_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= hwdata;
            end
            if (wr_expid) begin
                expid_q <= hwdata;
            end
            // An event in the clearing cycle stays recorded
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel pairing

    ddc_chan_s a_q;
    ddc_chan_s b_q;
    logic got_a_q;
    logic got_b_q;
    wire fire = got_a_q & got_b_q & ~simple_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_q <= '0;
            b_q <= '0;
            got_a_q <= 1'b0;
            got_b_q <= 1'b0;
        end else begin
            // Only framed fields arrive here, start and stop bits never do
            if (ch_a_valid) begin
                a_q <= ch_a;
            end
            if (ch_b_valid) begin
                b_q <= ch_b;
            end
            got_a_q <= ch_a_valid | (got_a_q & ~fire);
            got_b_q <= ch_b_valid | (got_b_q & ~fire);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Merge and diversity check

    // Secondary channel comes inverted on the compared fields
    wire b_bd = ~b_q.beacon_detect_flag;
    wire b_td = ~b_q.telegram_detect_flag;
    wire b_eu = ~b_q.system_unavailable_flag;
    wire b_eb = ~b_q.foreign_reception_flag;
    wire b_lt = ~b_q.link_test_flag;
    wire [`DDC_ANT_W-1:0] b_ant = ~b_q.antenna_id;

    wire crc_both = a_q.crc_ok & b_q.crc_ok;
    wire m_bd = a_q.beacon_detect_flag & b_bd;
    wire m_eb = a_q.foreign_reception_flag & b_eb;
    wire ss_zero = (a_q.strength == '0) | (b_q.strength == '0);
    wire [`DDC_SS_W-1:0] m_ss = ss_zero ? '0 : a_q.strength;
    // Telegram detect is taken from channel a when its checksum is good, otherwise from channel b
    wire m_td = a_q.crc_ok ? a_q.telegram_detect_flag : b_td;
    wire lt_mismatch = a_q.link_test_flag != b_lt;
    wire mismatch = (a_q.system_unavailable_flag != b_eu) | lt_mismatch | (a_q.antenna_id != b_ant);
    wire div_now = crc_both & mismatch;
    wire lid_err = (a_q.crc_ok & (a_q.link_id != exp_lid_a)) | (b_q.crc_ok & (b_q.link_id != exp_lid_b));
    // Foreign data during a link test is not treated as foreign
    wire foreign_now = m_eb & ~a_q.link_test_flag;

    ////////////////////////////////////////////////////////////////////////
    // Bit counter supervision

    logic [`DDC_CNT_W-1:0] exp_cnt_a_q;
    logic [`DDC_CNT_W-1:0] exp_cnt_b_q;
    logic cnt_init_q;
    wire slip_now = cnt_init_q & ((a_q.bit_count != exp_cnt_a_q) | (b_q.bit_count != exp_cnt_b_q));

    // Checked on every merged bit after the first, so a slip shows within one bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exp_cnt_a_q <= '0;
            exp_cnt_b_q <= '0;
            cnt_init_q <= 1'b0;
        end else if (fire) begin
            exp_cnt_a_q <= a_q.bit_count + `DDC_CNT_W'(1);
            exp_cnt_b_q <= b_q.bit_count - `DDC_CNT_W'(1);
            cnt_init_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Merged outputs

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            merged <= '0;
            merged_valid <= 1'b0;
            div_fail <= 1'b0;
        end else begin
            merged_valid <= fire & op_ok;
            if (fire) begin
                merged.beacon_detect_flag <= m_bd;
                merged.telegram_detect_flag <= m_td;
                merged.system_unavailable_flag <= a_q.system_unavailable_flag;
                merged.foreign_reception_flag <= m_eb;
                merged.link_test_flag <= a_q.link_test_flag;
                merged.strength <= m_ss;
                merged.antenna_id <= a_q.antenna_id;
                merged.data_ok <= op_ok & ~foreign_now & ~div_now;
                div_fail <= div_now;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reaction timers

    logic eb_hold_q;
    logic lt_hold_q;
    logic [TW-1:0] eb_cnt_q;
    logic [TW-1:0] lt_cnt_q;
    wire eb_stuck = eb_cnt_q == TW'(REACT_CYC);
    wire lt_stuck = lt_cnt_q == TW'(REACT_CYC);

    // A flag held for the whole reaction time counts as stuck
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eb_hold_q <= 1'b0;
            lt_hold_q <= 1'b0;
            eb_cnt_q <= '0;
            lt_cnt_q <= '0;
        end else begin
            if (fire) begin
                eb_hold_q <= foreign_now;
                lt_hold_q <= a_q.link_test_flag & ~lt_mismatch;
            end
            if (!eb_hold_q) begin
                eb_cnt_q <= '0;
            end else if (!eb_stuck) begin
                eb_cnt_q <= eb_cnt_q + TW'(1);
            end
            if (!lt_hold_q) begin
                lt_cnt_q <= '0;
            end else if (!lt_stuck) begin
                lt_cnt_q <= lt_cnt_q + TW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Simplified variant

    logic [1:0] lnk_s;
    logic ser_bit;
    logic ser_valid;
    logic ser_silent;

    ddc_sync #(.W(2)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .din({link_clk, link_data}),
        .dout(lnk_s)
    );

    ddc_serial #(.SILENT_CYC(SILENT_CYC)) u_serial (
        .clk(hclk),
        .rst_n(hresetn),
        .enable(simple_mode & link_used),
        .lclk_s(lnk_s[1]),
        .ldata_s(lnk_s[0]),
        .bit_q(ser_bit),
        .valid_q(ser_valid),
        .silent_q(ser_silent)
    );

    // The stream is passed on raw; decoding happens further on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_bit <= 1'b0;
            raw_valid <= 1'b0;
            raw_shift_q <= '0;
            raw_cnt_q <= '0;
        end else begin
            raw_valid <= ser_valid & op_ok;
            raw_bit <= ser_bit;
            if (ser_valid) begin
                raw_shift_q <= {raw_shift_q[14:0], ser_bit};
                raw_cnt_q <= raw_cnt_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and reactions

    assign stat_set[`DDC_ST_DIV] = fire & div_now;
    assign stat_set[`DDC_ST_SLIP] = fire & slip_now;
    assign stat_set[`DDC_ST_LID] = fire & lid_err;
    assign stat_set[`DDC_ST_CRC] = fire & ~crc_both;
    assign stat_set[`DDC_ST_FOREIGN] = eb_stuck;
    assign stat_set[`DDC_ST_LTEST] = lt_stuck | (fire & crc_both & lt_mismatch);
    assign stat_set[`DDC_ST_SILENT] = ser_silent;

    wire link_fault = link_used & (stat_q[`DDC_ST_SLIP] | stat_q[`DDC_ST_LID] | stat_q[`DDC_ST_SILENT]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_confirm <= 1'b0;
            reaction <= 1'b0;
        end else begin
            hs_confirm <= hs_request & ~link_fault;
            reaction <= link_fault | stat_q[`DDC_ST_FOREIGN] | stat_q[`DDC_ST_LTEST];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_bd_zero_wins: assert property (
        fire && (!a_q.beacon_detect_flag || b_q.beacon_detect_flag) |=> !merged.beacon_detect_flag)
        else $error("beacon detect zero lost in merge");
    chk_eb_zero_wins: assert property (
        fire && (!a_q.foreign_reception_flag || b_q.foreign_reception_flag) |=> !merged.foreign_reception_flag)
        else $error("foreign flag zero lost in merge");
    chk_eu_true_compare: assert property (
        fire && crc_both && a_q.system_unavailable_flag == b_q.system_unavailable_flag |=> div_fail)
        else $error("unavailability mismatch not flagged");
    chk_ss_zero_wins: assert property (
        fire && (a_q.strength == '0 || b_q.strength == '0) |=> merged.strength == '0)
        else $error("zero strength not taken");
    chk_lid_sticky: assert property (
        fire && lid_err |=> stat_q[`DDC_ST_LID] ##1 (stat_q[`DDC_ST_LID] || $past(wr_stat)))
        else $error("link id error not held");
    chk_slip_detect: assert property (
        fire && cnt_init_q && a_q.bit_count != exp_cnt_a_q |=> stat_q[`DDC_ST_SLIP] ##1 reaction || !link_used)
        else $error("counter slip not reported");
    chk_crc_skip: assert property (
        fire && !crc_both |=> !div_fail)
        else $error("diversity checked despite crc failure");
    chk_state_gate: assert property (
        merged_valid |-> $past(op_ok) && $past(got_a_q) && $past(got_b_q))
        else $error("merged data outside permitted state");
    chk_hs_withheld: assert property (
        link_fault |=> !hs_confirm)
        else $error("standby confirmed despite link fault");
    chk_foreign_invalid: assert property (
        fire && foreign_now |=> merged_valid -> !merged.data_ok)
        else $error("foreign data not invalidated");

    cov_merge_ok: cover property (fire && crc_both && !mismatch ##1 merged_valid);
    cov_div_fail: cover property (fire && div_now);
    cov_raw_bit: cover property (ser_valid ##1 raw_valid);
endmodule

// ### common/ddc_map.svh
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH

// Field widths of one channel word
`define DDC_ANT_W 3
`define DDC_LID_W 2
`define DDC_CNT_W 3
`define DDC_SS_W 4

// Register byte offsets
`define DDC_CTRL_OFS 8'h00
`define DDC_EXPID_OFS 8'h04
`define DDC_STAT_OFS 8'h08
`define DDC_MERGE_OFS 8'h0c
`define DDC_RAW_OFS 8'h10

// Control register fields
`define DDC_CTRL_LINK_USED 0
`define DDC_CTRL_SIMPLE 1
`define DDC_CTRL_OPST_LO 2
`define DDC_CTRL_HSREQ 4
`define DDC_OP_HS 2'h1
`define DDC_OP_DA 2'h2

// Expected link identifier fields
`define DDC_EXPID_A_LO 0
`define DDC_EXPID_B_LO 4

// Sticky status bits
`define DDC_ST_DIV 0
`define DDC_ST_SLIP 1
`define DDC_ST_LID 2
`define DDC_ST_CRC 3
`define DDC_ST_FOREIGN 4
`define DDC_ST_LTEST 5
`define DDC_ST_SILENT 6
`define DDC_ST_W 7

// Reset values
`define DDC_CTRL_RST 32'h0000_0000
`define DDC_EXPID_RST 32'h0000_0010

// Timing
`define DDC_CLK_KHZ 25000
`define DDC_REACT_MS 1000
`define DDC_LINK_KBPS 50
`define DDC_SILENT_BITS 4

`endif

// ### common/ddc_pkg.sv
`include "ddc_map.svh"

package ddc_pkg;

    // One ASK bit as delivered by one channel's framing logic
    typedef struct packed {
        logic beacon_detect_flag;
        logic telegram_detect_flag;
        logic system_unavailable_flag;
        logic foreign_reception_flag;
        logic link_test_flag;
        logic [`DDC_SS_W-1:0] strength;
        logic [`DDC_ANT_W-1:0] antenna_id;
        logic [`DDC_LID_W-1:0] link_id;
        logic [`DDC_CNT_W-1:0] bit_count;
        logic crc_ok;
    } ddc_chan_s;

    // Merged result of both channels
    typedef struct packed {
        logic beacon_detect_flag;
        logic telegram_detect_flag;
        logic system_unavailable_flag;
        logic foreign_reception_flag;
        logic link_test_flag;
        logic [`DDC_SS_W-1:0] strength;
        logic [`DDC_ANT_W-1:0] antenna_id;
        logic data_ok;
    } ddc_merge_s;

endpackage

// ### hdl/ddc_sync.sv
`timescale 1ns/1ns

module ddc_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage feeds the second stage only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// ### hdl/ddc_serial.sv
`timescale 1ns/1ns
`include "ddc_map.svh"

module ddc_serial
    import ddc_pkg::*;
#(
    parameter int SILENT_CYC = (`DDC_CLK_KHZ / `DDC_LINK_KBPS) * `DDC_SILENT_BITS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic lclk_s,
    input wire logic ldata_s,
    output logic bit_q,
    output logic valid_q,
    output logic silent_q
);
    localparam int CW = $clog2(SILENT_CYC + 1);
    logic lclk_prev_q;
    logic [CW-1:0] idle_q;
    wire rise = lclk_s & ~lclk_prev_q;
    wire idle_full = (idle_q == CW'(SILENT_CYC));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lclk_prev_q <= 1'b0;
            bit_q <= 1'b0;
            valid_q <= 1'b0;
            idle_q <= '0;
            silent_q <= 1'b0;
        end else begin
            lclk_prev_q <= lclk_s;
            valid_q <= enable & rise;
            if (enable & rise) begin
                bit_q <= ldata_s;
            end
            // A stalled link clock counts as a link fault
            if (!enable || rise) begin
                idle_q <= '0;
            end else if (!idle_full) begin
                idle_q <= idle_q + CW'(1);
            end
            silent_q <= enable & idle_full;
        end
    end
endmodule

// ### verification/ddc_partner.sv
`timescale 1ns/1ns

// Behavioural transmission module: two diversified channel words and the raw link
module ddc_partner
    import ddc_pkg::*;
(
    input wire logic hclk,
    output ddc_chan_s ch_a,
    output logic ch_a_valid,
    output ddc_chan_s ch_b,
    output logic ch_b_valid,
    output logic link_clk,
    output logic link_data
);

    logic [2:0] cnt_q;

    initial begin
        cnt_q = 3'h0;
        ch_a = '0;
        ch_b = '1;
        ch_a_valid = 1'b0;
        ch_b_valid = 1'b0;
        link_clk = 1'b0;
        link_data = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Knobs m: 0 slip, 1 bad b checksum, 2 b unavailable not inverted,
    // 3 b detect zero, 4 b strength zero, 5 b telegram not inverted
    task automatic send(input ddc_chan_s w, input logic [5:0] m, input int gap);
        ddc_chan_s wa;
        ddc_chan_s wb;
        wa = w;
        wa.link_id = 2'h0;
        wa.bit_count = cnt_q;
        wb = wa ^ ddc_chan_s'({5'h1f, 4'h0, 3'h7, 6'h0});
        wb.link_id = 2'h1;
        wb.bit_count = 3'h0 - cnt_q;
        wb.crc_ok = ~m[1];
        if (m[2]) wb.system_unavailable_flag = w.system_unavailable_flag;
        if (m[3]) wb.beacon_detect_flag = 1'b1;
        if (m[4]) wb.strength = 4'h0;
        if (m[5]) wb.telegram_detect_flag = w.telegram_detect_flag;
        @(posedge hclk);
        ch_a <= wa;
        ch_a_valid <= 1'b1;
        if (gap == 0) begin
            ch_b <= wb;
            ch_b_valid <= 1'b1;
        end else begin
            @(posedge hclk);
            ch_a_valid <= 1'b0;
            ch_a <= ~wa;
            repeat (gap - 1) @(posedge hclk);
            ch_b <= wb;
            ch_b_valid <= 1'b1;
        end
        @(posedge hclk);
        // Released words flip so a stale value is never mistaken for data
        ch_a_valid <= 1'b0;
        ch_b_valid <= 1'b0;
        ch_a <= ~wa;
        ch_b <= ~wb;
        if (!m[0]) cnt_q = cnt_q + 3'h1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Link runs only while asked; clock stands still between frames
    task automatic send_bits(input logic [7:0] bits, input int n);
        @(posedge hclk);
        for (int i = n - 1; i >= 0; i--) begin
            link_data <= bits[i];
            repeat (4) @(posedge hclk);
            link_clk <= 1'b1;
            repeat (4) @(posedge hclk);
            link_clk <= 1'b0;
        end
        link_data <= ~link_data;
    endtask

endmodule

// ### verification/ddc_top_tb.sv
`timescale 1ns/1ns
`include "ddc_map.svh"

module ddc_top_tb
    import ddc_pkg::*;
;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    ddc_chan_s ch_a;
    ddc_chan_s ch_b;
    logic ch_a_valid;
    logic ch_b_valid;
    logic link_clk;
    logic link_data;
    ddc_merge_s merged;
    logic merged_valid;
    logic div_fail;
    logic raw_bit;
    logic raw_valid;
    logic hs_confirm;
    logic reaction;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] raw_seen = 8'h00;

    assign hready = hreadyout;

    // Collects the bits shown on the raw pins, newest in the lsb
    always @(posedge hclk) begin
        if (raw_valid) begin
            raw_seen <= {raw_seen[6:0], raw_bit};
        end
    end

    initial begin
        forever #20 hclk = ~hclk;
    end

    // Short counts keep the one-second alarms within a brief run
    ddc_top #(.REACT_CYC(200), .SILENT_CYC(40)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch_a(ch_a), .ch_a_valid(ch_a_valid),
        .ch_b(ch_b), .ch_b_valid(ch_b_valid), .link_clk(link_clk), .link_data(link_data), .merged(merged),
        .merged_valid(merged_valid), .div_fail(div_fail), .raw_bit(raw_bit), .raw_valid(raw_valid),
        .hs_confirm(hs_confirm), .reaction(reaction));

    ddc_partner u_bm (.hclk(hclk), .ch_a(ch_a), .ch_a_valid(ch_a_valid), .ch_b(ch_b),
        .ch_b_valid(ch_b_valid), .link_clk(link_clk), .link_data(link_data));

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(nm, exp, q & mask);
        chk({nm, " resp"}, 32'h0, {31'h0, hresp});
    endtask

    function automatic ddc_chan_s wd(input logic [4:0] f, input logic [3:0] ss, input logic [2:0] ant);
        return ddc_chan_s'({f, ss, ant, 2'h0, 3'h0, 1'b1});
    endfunction

    // Merged level is compared only where no diversity failure is expected
    task automatic pr(input string nm, input ddc_chan_s w, input logic [5:0] m, input int gap,
        input logic vexp, input logic dexp);
        logic [11:0] e;
        e = {w.beacon_detect_flag & ~m[3], w.telegram_detect_flag, w.system_unavailable_flag,
            w.foreign_reception_flag, w.link_test_flag, m[4] ? 4'h0 : w.strength, w.antenna_id};
        u_bm.send(w, m, gap);
        // The pair is taken at the edge send returns on; the merge shows after the next one
        @(posedge hclk);
        #1;
        chk({nm, " valid"}, {31'h0, vexp}, {31'h0, merged_valid});
        chk({nm, " div"}, {31'h0, dexp}, {31'h0, div_fail});
        if (!dexp) chk({nm, " merged"}, {20'h0, e}, {20'h0, merged[12:1]});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd("ctrl", `DDC_CTRL_OFS, `DDC_CTRL_RST, '1);
        rd("expid", `DDC_EXPID_OFS, `DDC_EXPID_RST, '1);
        rd("unmapped", 8'h20, 32'h0, '1);
        wr(`DDC_CTRL_OFS, 32'h18);
        repeat (2) @(posedge hclk);
        #1;
        chk("confirm", 32'h1, {31'h0, hs_confirm});
        pr("seed", wd(5'h00, 4'h0, 3'h0), 6'h00, 0, 1'b1, 1'b0);
        pr("and", wd(5'h12, 4'h5, 3'h3), 6'h00, 3, 1'b1, 1'b0);
        pr("zero", wd(5'h12, 4'h5, 3'h3), 6'h08, 0, 1'b1, 1'b0);
        pr("strength", wd(5'h00, 4'h9, 3'h6), 6'h10, 0, 1'b1, 1'b0);
        pr("telegram", wd(5'h08, 4'h1, 3'h1), 6'h20, 0, 1'b1, 1'b0);
        pr("unavail", wd(5'h04, 4'h1, 3'h1), 6'h04, 0, 1'b1, 1'b1);
        rd("status div", `DDC_STAT_OFS, 32'h1, 32'hf);
        pr("crc skip", wd(5'h04, 4'h1, 3'h1), 6'h06, 0, 1'b1, 1'b0);
        rd("status crc", `DDC_STAT_OFS, 32'h8, 32'h8);
        wr(`DDC_EXPID_OFS, 32'h0000_0012);
        pr("lid", wd(5'h00, 4'h2, 3'h2), 6'h00, 0, 1'b1, 1'b0);
        rd("status lid", `DDC_STAT_OFS, 32'h4, 32'h4);
        wr(`DDC_EXPID_OFS, `DDC_EXPID_RST);
        wr(`DDC_STAT_OFS, 32'h7f);
        rd("status clear", `DDC_STAT_OFS, 32'h0, 32'h7f);
        pr("slip", wd(5'h00, 4'h2, 3'h2), 6'h01, 0, 1'b1, 1'b0);
        pr("after slip", wd(5'h00, 4'h2, 3'h2), 6'h00, 0, 1'b1, 1'b0);
        rd("status slip", `DDC_STAT_OFS, 32'h2, 32'h2);
        wr(`DDC_CTRL_OFS, 32'h10);
        pr("idle state", wd(5'h10, 4'h2, 3'h2), 6'h00, 0, 1'b0, 1'b0);
        wr(`DDC_CTRL_OFS, 32'h08);
        pr("foreign", wd(5'h02, 4'h2, 3'h2), 6'h00, 0, 1'b1, 1'b0);
        chk("foreign data_ok", 32'h0, {31'h0, merged.data_ok});
        repeat (220) @(posedge hclk);
        pr("ltest", wd(5'h01, 4'h2, 3'h2), 6'h00, 0, 1'b1, 1'b0);
        repeat (220) @(posedge hclk);
        pr("clean", wd(5'h00, 4'h2, 3'h2), 6'h00, 0, 1'b1, 1'b0);
        chk("clean data_ok", 32'h1, {31'h0, merged.data_ok});
        rd("status alarms", `DDC_STAT_OFS, 32'h30, 32'h30);
        chk("alarm reaction", 32'h1, {31'h0, reaction});
        wr(`DDC_STAT_OFS, 32'h7f);
        wr(`DDC_CTRL_OFS, 32'h0b);
        chk("reaction clear", 32'h0, {31'h0, reaction});
        u_bm.send_bits(8'h0b, 4);
        repeat (8) @(posedge hclk);
        rd("raw", `DDC_RAW_OFS, 32'h0400000b, 32'hff00ffff);
        chk("raw pins", 32'h0000000b, {24'h0, raw_seen});
        repeat (60) @(posedge hclk);
        rd("status silent", `DDC_STAT_OFS, 32'h40, 32'h40);
        wr(`DDC_CTRL_OFS, 32'h1b);
        repeat (2) @(posedge hclk);
        #1;
        chk("withheld", 32'h0, {31'h0, hs_confirm});
        chk("fault reaction", 32'h1, {31'h0, reaction});
        wrap_up();
    end

endmodule
